/* gated_counter_core.sv */
// gated 16-bit incrementing counter core with prescaler and overflow flag
`timescale 1ns/10ps
// Contract
// [R01] sixteen-bit counter, two eight-bit halves
// [R02] byte writes replace count immediately
// [R03] internal source counts every instruction cycle
// [R04] external source counts each rising edge
// [R05] on and gate mode choose off/always/gated
// [R06] wake only on external async overflow
// [R07] prescaler divides by 1, 2, 4, 8
// [R08] prescaler hidden, cleared on count write
// [R09] system clock source adds four per cycle
// [R10] sticky overflow flag, enabled interrupt request
module gated_counter_core
   import gated_counter_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire counter_control_t control,
   input wire count_write_t count_write,
   input wire logic ext_clock_pin,
   input wire logic gate_permit,
   input wire logic overflow_clear,
   input wire logic overflow_irq_enable,
   input wire logic sleeping,
   output logic [7:0] count_high_byte,
   output logic [7:0] count_low_byte,
   output logic overflow_flag,
   output logic overflow_irq,
   output logic wake_request
);
   logic [15:0] count;
   logic [2:0] prescale;
   logic [1:0] instr_div;
   logic ext_meta, ext_sync, ext_prev;
   logic gate_meta, gate_sync;
   logic count_enable, source_tick, prescale_done, step_now, wraps;
   logic [15:0] step;
   logic [16:0] next_sum;
   run_mode_t mode;

   function automatic logic [2:0] prescale_last(input logic [1:0] sel);
      prescale_last = 3'((4'h1 << sel) - 4'h1);
   endfunction

   // pins come from outside the clock domain
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
         gate_meta <= 1'b0;
         gate_sync <= 1'b0;
      end else begin
         ext_meta <= ext_clock_pin;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
         gate_meta <= gate_permit;
         gate_sync <= gate_meta;
      end
   end

   // instruction cycle is four system clocks
   always_ff @(posedge clk) begin
      if (!rstn) begin
         instr_div <= 2'h0;
      end else begin
         instr_div <= instr_div + 2'h1;
      end
   end

   always_comb begin
      if (!control.counter_on) begin
         mode = mode_off; // see [R05]
      end else if (!control.gate_enable_mode) begin
         mode = mode_always; // see [R05]
      end else begin
         mode = mode_gated; // see [R05]
      end
   end

   assign count_enable = (mode == mode_always) || (mode == mode_gated && gate_sync);

   always_comb begin
      case (control.clock_source_select)
         source_instr: source_tick = (instr_div == instr_div_last); // see [R03]
         source_sys: source_tick = (instr_div == instr_div_last); // see [R09]
         source_ext, source_cap: source_tick = ext_sync && !ext_prev; // see [R04]
         default: source_tick = 1'b0;
      endcase
   end

   assign prescale_done = (prescale == prescale_last(control.prescale_select)); // see [R07]
   assign step_now = count_enable && source_tick && prescale_done;
   // full-rate source: four counts per instruction cycle, loses two lsbs of resolution
   assign step = (control.clock_source_select == source_sys) ? fast_step : unit_step; // see [R09]
   assign next_sum = {1'b0, count} + {1'b0, step};
   assign wraps = step_now && next_sum[16];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prescale <= prescale_reset;
      end else if (count_write.write_high || count_write.write_low) begin
         prescale <= prescale_reset; // see [R08]
      end else if (count_enable && source_tick) begin
         prescale <= prescale_done ? prescale_reset : prescale + 3'h1; // see [R07]
      end
   end

   // write wins over a coincident increment
   always_ff @(posedge clk) begin
      if (!rstn) begin
         count <= count_reset;
      end else if (count_write.write_high || count_write.write_low) begin
         if (count_write.write_high) begin
            count[15:8] <= count_write.data; // see [R02]
         end
         if (count_write.write_low) begin
            count[7:0] <= count_write.data; // see [R02]
         end
      end else if (step_now) begin
         count <= next_sum[15:0]; // see [R01]
      end
   end

   assign count_high_byte = count[15:8]; // see [R01]
   assign count_low_byte = count[7:0];

   // set beats clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         overflow_flag <= 1'b0;
      end else if (wraps) begin
         overflow_flag <= 1'b1; // see [R10]
      end else if (overflow_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   assign overflow_irq = overflow_flag && overflow_irq_enable; // see [R10]

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= sleeping && wraps && control.async_mode
                         && (control.clock_source_select == source_ext); // see [R06]
      end
   end

   property p_off_holds;
      @(posedge clk) disable iff (!rstn)
      (!control.counter_on && !count_write.write_high && !count_write.write_low) |=> (count == $past(count));
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("count moved while off"); // see [R05]

   property p_gate_closed;
      @(posedge clk) disable iff (!rstn)
      (control.counter_on && control.gate_enable_mode && !gate_sync
       && !count_write.write_high && !count_write.write_low) |=> (count == $past(count));
   endproperty
   a_gate_closed: assert property (p_gate_closed) else $error("count moved with gate closed"); // see [R05]

   property p_write_low;
      @(posedge clk) disable iff (!rstn)
      count_write.write_low |=> (count_low_byte == $past(count_write.data));
   endproperty
   a_write_low: assert property (p_write_low) else $error("low byte write lost"); // see [R02]

   property p_write_high;
      @(posedge clk) disable iff (!rstn)
      count_write.write_high |=> (count_high_byte == $past(count_write.data));
   endproperty
   a_write_high: assert property (p_write_high) else $error("high byte write lost"); // see [R02]

   property p_prescale_clear;
      @(posedge clk) disable iff (!rstn)
      (count_write.write_high || count_write.write_low) |=> (prescale == prescale_reset);
   endproperty
   a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared"); // see [R08]

   property p_step_size;
      @(posedge clk) disable iff (!rstn)
      (step_now && !count_write.write_high && !count_write.write_low)
      |=> (count == 16'($past(count) + $past(step)));
   endproperty
   a_step_size: assert property (p_step_size) else $error("wrong step size"); // see [R09]

   sequence s_wrap;
      wraps;
   endsequence
   property p_flag_set;
      @(posedge clk) disable iff (!rstn)
      s_wrap |=> overflow_flag ##0 (overflow_irq == overflow_irq_enable);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overflow flag not set"); // see [R10]

   property p_flag_sticky;
      @(posedge clk) disable iff (!rstn)
      (overflow_flag && !overflow_clear) |=> overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped"); // see [R10]

   property p_wake_cause;
      @(posedge clk) disable iff (!rstn)
      wake_request |-> $past(control.async_mode) && ($past(control.clock_source_select) == source_ext);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without async external"); // see [R06]

   // tick count kept apart from the prescaler, so a prescaler fault shows
   logic [2:0] ticks_seen;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ticks_seen <= 3'h0;
      end else if (count_write.write_high || count_write.write_low || step_now) begin
         ticks_seen <= 3'h0;
      end else if (count_enable && source_tick) begin
         ticks_seen <= ticks_seen + 3'h1;
      end
   end

   property p_prescale_range;
      @(posedge clk) disable iff (!rstn)
      (count_enable && source_tick) |-> (step_now == (ticks_seen == prescale_last(control.prescale_select)));
   endproperty
   a_prescale_range: assert property (p_prescale_range) else $error("step off prescale boundary"); // see [R07]
endmodule

/* gated_counter_pkg.sv */
// package of constants and types for the gated 16-bit counter core
package gated_counter_pkg;
   localparam int count_width = 16;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [15:0] count_max = 16'hffff;
   localparam logic [2:0] prescale_reset = 3'h0;
   localparam logic [1:0] source_instr = 2'h0;
   localparam logic [1:0] source_sys = 2'h1;
   localparam logic [1:0] source_ext = 2'h2;
   localparam logic [1:0] source_cap = 2'h3;
   localparam logic [15:0] fast_step = 16'h0004;
   localparam logic [15:0] unit_step = 16'h0001;
   localparam logic [1:0] instr_div_last = 2'h3;

   typedef enum logic [1:0] {
      mode_off = 2'b00,
      mode_always = 2'b01,
      mode_gated = 2'b10
   } run_mode_t;

   typedef struct packed {
      logic counter_on;
      logic gate_enable_mode;
      logic async_mode;
      logic [1:0] prescale_select;
      logic [1:0] clock_source_select;
   } counter_control_t;

   typedef struct packed {
      logic write_high;
      logic write_low;
      logic [7:0] data;
   } count_write_t;
endpackage

/* ext_source.sv */
// model of the external count clock and gate level
`timescale 1ns/10ps
module ext_source (
   input wire logic clk,
   output logic ext_clock_pin,
   output logic gate_permit
);
   initial begin
      ext_clock_pin = 1'b0;
      gate_permit = 1'b0;
   end
   // clock stands low between bursts; w sets fast or slow edges
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         @(posedge clk) ext_clock_pin <= 1'b1;
         repeat (w) @(posedge clk);
         ext_clock_pin <= 1'b0;
         repeat (w) @(posedge clk);
      end
   endtask
   task automatic set_gate(input logic g);
      @(posedge clk) gate_permit <= g;
   endtask
endmodule

/* gated_16bit_counter_core_tb.sv */
// self-checking bench for the gated counter core
`timescale 1ns/10ps
module gated_16bit_counter_core_tb;
   import gated_counter_pkg::*;
   logic clk, rstn, ext_clock_pin, gate_permit, overflow_clear, overflow_irq_enable, sleeping, chk;
   counter_control_t control;
   count_write_t count_write;
   logic [7:0] count_high_byte, count_low_byte;
   logic overflow_flag, overflow_irq, wake_request;
   logic [3:0] wakes;
   logic [21:0] exp_q[$];
   logic [21:0] seen;
   int error_cnt, n_checks;
   gated_counter_core u_dut (.clk(clk), .rstn(rstn), .control(control), .count_write(count_write),
      .ext_clock_pin(ext_clock_pin), .gate_permit(gate_permit), .overflow_clear(overflow_clear),
      .overflow_irq_enable(overflow_irq_enable), .sleeping(sleeping), .count_high_byte(count_high_byte),
      .count_low_byte(count_low_byte), .overflow_flag(overflow_flag), .overflow_irq(overflow_irq),
      .wake_request(wake_request));
   ext_source u_src (.clk(clk), .ext_clock_pin(ext_clock_pin), .gate_permit(gate_permit));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rstn !== 1'b1) wakes <= 4'h0;
      else if (wake_request === 1'b1) wakes <= wakes + 4'h1;
   end
   assign seen = {count_high_byte, count_low_byte, overflow_flag, overflow_irq, wakes};
   // oldest note against the settled outputs
   always @(negedge clk) begin
      if (chk === 1'b1 && exp_q.size() > 0) begin
         n_checks++;
         if (exp_q[0] !== seen) begin
            error_cnt++;
            $display("ERROR outputs expected %h seen %h", exp_q[0], seen);
         end
         void'(exp_q.pop_front());
      end
   end
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic expect_out(input logic [15:0] c, input logic f, i, input logic [3:0] w);
      exp_q.push_back({c, f, i, w});
      @(posedge clk) chk <= 1'b1;
      @(posedge clk) chk <= 1'b0;
   endtask
   task automatic wr(input logic hi, lo, input logic [7:0] d);
      @(posedge clk) count_write <= '{hi, lo, d};
      @(posedge clk) count_write <= '0;
   endtask
   task automatic ctl(input logic on, ge, input logic [1:0] ps, src);
      @(posedge clk) control <= '{on, ge, control.async_mode, ps, src};
   endtask
   task automatic clr;
      @(posedge clk) overflow_clear <= 1'b1;
      @(posedge clk) overflow_clear <= 1'b0;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      complete_run();
   end
   initial begin
      logic [15:0] d;
      int n;
      rstn = 1'b0;
      control = '0;
      count_write = '0;
      overflow_clear = 1'b0;
      overflow_irq_enable = 1'b0;
      sleeping = 1'b0;
      chk = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      void'($urandom(95));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      expect_out(16'h0000, 1'b0, 1'b0, 4'h0);
      d = 16'($urandom);
      wr(1'b1, 1'b0, d[15:8]);
      wr(1'b0, 1'b1, d[7:0]);
      expect_out(d, 1'b0, 1'b0, 4'h0);
      // each window holds exactly three prescaled instruction ticks
      for (int p = 0; p < 4; p++) begin
         wr(1'b1, 1'b1, 8'h10);
         ctl(1'b1, 1'b0, 2'(p), source_instr);
         repeat (12 * (1 << p) - 1) @(posedge clk);
         ctl(1'b0, 1'b0, 2'(p), source_instr);
         expect_out(16'h1013, 1'b0, 1'b0, 4'h0);
      end
      // three ticks leave the divide-by-four prescaler one short; a write must drop that
      wr(1'b1, 1'b1, 8'h10);
      ctl(1'b1, 1'b0, 2'h2, source_instr);
      repeat (11) @(posedge clk);
      ctl(1'b0, 1'b0, 2'h2, source_instr);
      wr(1'b1, 1'b1, 8'h20);
      ctl(1'b1, 1'b0, 2'h2, source_instr);
      repeat (11) @(posedge clk);
      ctl(1'b0, 1'b0, 2'h2, source_instr);
      expect_out(16'h2020, 1'b0, 1'b0, 4'h0);
      wr(1'b1, 1'b1, 8'h00);
      ctl(1'b1, 1'b0, 2'h1, source_sys);
      repeat (63) @(posedge clk);
      ctl(1'b0, 1'b0, 2'h1, source_sys);
      expect_out(16'h0020, 1'b0, 1'b0, 4'h0);
      for (int s = 2; s < 4; s++) begin
         n = 1 + $urandom % 6;
         wr(1'b1, 1'b1, 8'h00);
         ctl(1'b1, 1'b0, 2'h0, 2'(s));
         u_src.pulses(n, 2 + s);
         repeat (6) @(posedge clk);
         ctl(1'b0, 1'b0, 2'h0, 2'(s));
         expect_out(16'(n), 1'b0, 1'b0, 4'h0);
      end
      for (int i = 0; i < 4; i++) begin
         u_src.set_gate(i == 3);
         wr(1'b1, 1'b1, 8'h00);
         ctl(i != 0, i != 2, 2'h0, source_instr);
         repeat (39) @(posedge clk);
         ctl(1'b0, i != 2, 2'h0, source_instr);
         expect_out((i >= 2) ? 16'h000a : 16'h0000, 1'b0, 1'b0, 4'h0);
      end
      overflow_irq_enable <= 1'b1;
      wr(1'b1, 1'b1, 8'hff);
      ctl(1'b1, 1'b0, 2'h0, source_instr);
      repeat (3) @(posedge clk);
      ctl(1'b0, 1'b0, 2'h0, source_instr);
      expect_out(16'h0000, 1'b1, 1'b1, 4'h0);
      overflow_irq_enable <= 1'b0;
      clr();
      expect_out(16'h0000, 1'b0, 1'b0, 4'h0);
      // wake only with async mode set while asleep
      for (int a = 0; a < 2; a++) begin
         @(posedge clk) control.async_mode <= a[0];
         sleeping <= 1'b1;
         wr(1'b1, 1'b1, 8'hff);
         ctl(1'b1, 1'b0, 2'h0, source_ext);
         u_src.pulses(1, 3);
         repeat (6) @(posedge clk);
         ctl(1'b0, 1'b0, 2'h0, source_ext);
         expect_out(16'h0000, 1'b1, 1'b0, 4'(a));
         clr();
      end
      // mid-run reset with the flag set, a loaded count and a counted wake
      wr(1'b1, 1'b1, 8'hff);
      ctl(1'b1, 1'b0, 2'h0, source_instr);
      repeat (3) @(posedge clk);
      ctl(1'b0, 1'b0, 2'h0, source_instr);
      wr(1'b1, 1'b1, 8'h5a);
      @(posedge clk) rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      expect_out(16'h0000, 1'b0, 1'b0, 4'h0);
      complete_run();
   end
endmodule
